// [rtl/gpb_pkg.sv]
// Package of offsets, field positions and reset values for the GPIO block.
package gpb_pkg;

  localparam logic [7:0] OFS_PA_PIN   = 8'h00;
  localparam logic [7:0] OFS_PA_LAT   = 8'h04;
  localparam logic [7:0] OFS_PA_DIR   = 8'h08;
  localparam logic [7:0] OFS_ANA_CFG  = 8'h0C;
  localparam logic [7:0] OFS_PB_PIN   = 8'h10;
  localparam logic [7:0] OFS_PB_LAT   = 8'h14;
  localparam logic [7:0] OFS_PB_DIR   = 8'h18;
  localparam logic [7:0] OFS_INT_MAIN = 8'h1C;
  localparam logic [7:0] OFS_INT_TWO  = 8'h20;
  localparam logic [7:0] OFS_ALT_CFG  = 8'h24;

  localparam int BIT_CHG_FLAG  = 0;
  localparam int BIT_PU_DIS_N  = 7;
  localparam int BIT_PJ_PU     = 7;
  localparam int BIT_PD_PU     = 7;
  localparam int BIT_PE_PU     = 6;
  localparam int BIT_LED_EN    = 0;
  localparam int BIT_COMPARATOR_REF_VOLTAGE_OUT_EN  = 1;
  localparam int BIT_CCP_SEL   = 2;
  localparam int BIT_EXT_MODE  = 3;
  localparam int BIT_PKG_LARGE = 4;

  localparam logic [5:0] RST_PA_DIR  = 6'h3F;
  localparam logic [7:0] RST_PB_DIR  = 8'hFF;
  localparam logic [3:0] RST_ANA_CFG = 4'h0;
  localparam logic [4:0] RST_ALT_CFG = 5'h04;
  localparam logic       RST_PU_DIS_N = 1'b1;
  // Analog channel k is selected while the select code is at most
  // ANA_LIMIT minus k.
  localparam logic [3:0] ANA_LIMIT   = 4'hA;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       mm_dst;
    logic [7:0] addr;
  } gpb_req_s;

endpackage

// [rtl/gpb_gpio_top.sv]
// Port A and port B GPIO block with AHB-Lite register slave.
`timescale 1ns/100ps
module gpb_gpio_top
  import gpb_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // High when the current write is the target of a memory move.
  input  wire logic        memory_to_memory_move,
  // Port A pins.
  input  wire logic [5:0]  pa_in,
  output logic      [5:0]  pa_out,
  output logic      [5:0]  pa_oe_n,
  // Port B pins.
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe_n,
  output logic      [7:0]  pb_pullup_en,
  // Pull-up enables for other ports.
  output logic             port_j_pullup_enable,
  output logic             port_d_pullup_enable,
  output logic             port_e_pullup_enable,
  // Peripheral alternate functions.
  input  wire logic        ethernet_led_a_out,
  input  wire logic        ethernet_led_b_out,
  input  wire logic        pwm_two_output_a,
  output logic             timer_zero_ext_clock_in,
  output logic             ecp2_on_port_b3,
  output logic             ecp2_on_port_e7,
  // Change flag and wake request.
  output logic             port_b_change_flag,
  output logic             port_b_change_wake
);

  gpb_req_s    req_ff, nxt_req;
  logic        rdy_ff, nxt_rdy;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        resp_ff;
  logic [5:0]  pa_lat_ff, nxt_pa_lat;
  logic [5:0]  pa_dir_ff, nxt_pa_dir;
  logic [3:0]  ana_ff, nxt_ana;
  logic [7:0]  pb_lat_ff, nxt_pb_lat;
  logic [7:0]  pb_dir_ff, nxt_pb_dir;
  logic        pu_dis_n_ff, nxt_pu_dis_n;
  logic        pj_pu_ff, nxt_pj_pu;
  logic        pd_pu_ff, nxt_pd_pu;
  logic        pe_pu_ff, nxt_pe_pu;
  logic [4:0]  alt_ff, nxt_alt;
  logic [3:0]  snap_ff, nxt_snap;
  logic        flag_ff, nxt_flag;
  logic        mis_ff, nxt_mis;
  logic [5:0]  pa_s1_ff, pa_s2_ff;
  logic [7:0]  pb_s1_ff, pb_s2_ff;
  logic [5:0]  pa_out_ff, nxt_pa_out;
  logic [5:0]  pa_oe_n_ff, nxt_pa_oe_n;
  logic [7:0]  pb_out_ff, nxt_pb_out;
  logic [7:0]  pb_oe_n_ff, nxt_pb_oe_n;
  logic [7:0]  pb_pu_ff, nxt_pb_pu;
  logic        t0ck_ff;
  logic        ecp_b3_ff, nxt_ecp_b3;
  logic        ecp_e7_ff, nxt_ecp_e7;
  logic [4:0]  ana_ch;
  logic [5:0]  pa_ana;
  logic [5:0]  pa_dig;
  logic [7:0]  rbyte;
  logic        take;
  logic        comparator_ref_voltage_out;

  // Analog channel decode; channel 4 sits on pin 5.
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      ana_ch[k] = (ana_ff <= (ANA_LIMIT - 4'(k)));
    end
    pa_ana = {ana_ch[4], 1'b0, ana_ch[3:0]};
  end

  assign comparator_ref_voltage_out = alt_ff[BIT_COMPARATOR_REF_VOLTAGE_OUT_EN];

  // Digital input path of port A; analog or reference use reads zero.
  always_comb begin
    pa_dig = pa_s2_ff & ~pa_ana;
    if (comparator_ref_voltage_out) begin
      pa_dig[2] = 1'b0;
    end
  end

  // Read data mux; unimplemented bits stay zero.
  always_comb begin
    rbyte = 8'h00;
    unique case (req_ff.addr)
      OFS_PA_PIN:   rbyte = {pj_pu_ff, 1'b0, pa_dig};
      OFS_PA_LAT:   rbyte = {pd_pu_ff, pe_pu_ff, pa_lat_ff};
      OFS_PA_DIR:   rbyte = {2'b00, pa_dir_ff};
      OFS_ANA_CFG:  rbyte = {4'h0, ana_ff};
      OFS_PB_PIN:   rbyte = pb_s2_ff;
      OFS_PB_LAT:   rbyte = pb_lat_ff;
      OFS_PB_DIR:   rbyte = pb_dir_ff;
      OFS_INT_MAIN: rbyte = {7'h00, flag_ff};
      OFS_INT_TWO:  rbyte = {pu_dis_n_ff, 7'h00};
      OFS_ALT_CFG:  rbyte = {3'h0, alt_ff};
      default:      rbyte = 8'h00;
    endcase
  end

  assign take = hsel & hready & htrans[1];

  // Bus and register state.
  always_comb begin
    nxt_req      = req_ff;
    nxt_rdy      = rdy_ff;
    nxt_rdat     = rdat_ff;
    nxt_pa_lat   = pa_lat_ff;
    nxt_pa_dir   = pa_dir_ff;
    nxt_ana      = ana_ff;
    nxt_pb_lat   = pb_lat_ff;
    nxt_pb_dir   = pb_dir_ff;
    nxt_pu_dis_n = pu_dis_n_ff;
    nxt_pj_pu    = pj_pu_ff;
    nxt_pd_pu    = pd_pu_ff;
    nxt_pe_pu    = pe_pu_ff;
    nxt_alt      = alt_ff;
    nxt_snap     = snap_ff;
    nxt_flag     = flag_ff;
    // Only input pins of the upper nibble take part.
    nxt_mis = |((pb_s2_ff[7:4] ^ snap_ff) & pb_dir_ff[7:4]);
    if (req_ff.rd) begin
      nxt_rdat = {24'h000000, rbyte};
      nxt_rdy  = 1'b1;
      if (req_ff.addr == OFS_PB_PIN) begin
        nxt_snap = pb_s2_ff[7:4];
      end
    end
    if (req_ff.wr) begin
      unique case (req_ff.addr)
        OFS_PA_PIN: begin
          nxt_pa_lat = hwdata[5:0];
          nxt_pj_pu  = hwdata[BIT_PJ_PU];
        end
        OFS_PA_LAT: begin
          nxt_pa_lat = hwdata[5:0];
          nxt_pd_pu  = hwdata[BIT_PD_PU];
          nxt_pe_pu  = hwdata[BIT_PE_PU];
        end
        OFS_PA_DIR:  nxt_pa_dir = hwdata[5:0];
        OFS_ANA_CFG: nxt_ana = hwdata[3:0];
        OFS_PB_PIN: begin
          nxt_pb_lat = hwdata[7:0];
          if (!req_ff.mm_dst) begin
            nxt_snap = pb_s2_ff[7:4];
          end
        end
        OFS_PB_LAT: nxt_pb_lat = hwdata[7:0];
        OFS_PB_DIR: nxt_pb_dir = hwdata[7:0];
        OFS_INT_MAIN: begin
          if (!hwdata[BIT_CHG_FLAG]) begin
            nxt_flag = 1'b0;
          end
        end
        OFS_INT_TWO: nxt_pu_dis_n = hwdata[BIT_PU_DIS_N];
        OFS_ALT_CFG: nxt_alt = hwdata[4:0];
        default: nxt_flag = nxt_flag;
      endcase
    end
    // A live mismatch sets the flag even in the cycle it is cleared.
    if (mis_ff) begin
      nxt_flag = 1'b1;
    end
    nxt_req.wr = 1'b0;
    nxt_req.rd = 1'b0;
    if (take) begin
      nxt_req.addr   = haddr[7:0];
      nxt_req.mm_dst = memory_to_memory_move;
      nxt_req.wr     = hwrite;
      nxt_req.rd     = ~hwrite;
      if (!hwrite) begin
        nxt_rdy = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff      <= '0;
      rdy_ff      <= 1'b1;
      rdat_ff     <= 32'h00000000;
      resp_ff     <= 1'b0;
      pa_lat_ff   <= 6'h00;
      pa_dir_ff   <= RST_PA_DIR;
      ana_ff      <= RST_ANA_CFG;
      pb_lat_ff   <= 8'h00;
      pb_dir_ff   <= RST_PB_DIR;
      pu_dis_n_ff <= RST_PU_DIS_N;
      pj_pu_ff    <= 1'b0;
      pd_pu_ff    <= 1'b0;
      pe_pu_ff    <= 1'b0;
      alt_ff      <= RST_ALT_CFG;
      snap_ff     <= 4'h0;
      flag_ff     <= 1'b0;
      mis_ff      <= 1'b0;
    end else begin
      req_ff      <= nxt_req;
      rdy_ff      <= nxt_rdy;
      rdat_ff     <= nxt_rdat;
      resp_ff     <= 1'b0;
      pa_lat_ff   <= nxt_pa_lat;
      pa_dir_ff   <= nxt_pa_dir;
      ana_ff      <= nxt_ana;
      pb_lat_ff   <= nxt_pb_lat;
      pb_dir_ff   <= nxt_pb_dir;
      pu_dis_n_ff <= nxt_pu_dis_n;
      pj_pu_ff    <= nxt_pj_pu;
      pd_pu_ff    <= nxt_pd_pu;
      pe_pu_ff    <= nxt_pe_pu;
      alt_ff      <= nxt_alt;
      snap_ff     <= nxt_snap;
      flag_ff     <= nxt_flag;
      mis_ff      <= nxt_mis;
    end
  end

  // Pin drive state.
  always_comb begin
    nxt_pa_out = pa_lat_ff;
    if (alt_ff[BIT_LED_EN]) begin
      nxt_pa_out[0] = ethernet_led_a_out;
      nxt_pa_out[1] = ethernet_led_b_out;
    end
    nxt_pa_oe_n = pa_dir_ff;
    if (comparator_ref_voltage_out) begin
      nxt_pa_oe_n[2] = 1'b1;
    end
    nxt_ecp_b3 = alt_ff[BIT_PKG_LARGE] & alt_ff[BIT_EXT_MODE]
                 & ~alt_ff[BIT_CCP_SEL];
    nxt_ecp_e7 = alt_ff[BIT_PKG_LARGE] & ~alt_ff[BIT_EXT_MODE];
    nxt_pb_out = pb_lat_ff;
    if (nxt_ecp_b3) begin
      nxt_pb_out[3] = pwm_two_output_a;
    end
    nxt_pb_oe_n = pb_dir_ff;
    nxt_pb_pu   = pb_dir_ff & {8{~pu_dis_n_ff}};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_s1_ff   <= 6'h00;
      pa_s2_ff   <= 6'h00;
      pb_s1_ff   <= 8'h00;
      pb_s2_ff   <= 8'h00;
      pa_out_ff  <= 6'h00;
      pa_oe_n_ff <= RST_PA_DIR;
      pb_out_ff  <= 8'h00;
      pb_oe_n_ff <= RST_PB_DIR;
      pb_pu_ff   <= 8'h00;
      t0ck_ff    <= 1'b0;
      ecp_b3_ff  <= 1'b0;
      ecp_e7_ff  <= 1'b0;
    end else begin
      pa_s1_ff   <= pa_in;
      pa_s2_ff   <= pa_s1_ff;
      pb_s1_ff   <= pb_in;
      pb_s2_ff   <= pb_s1_ff;
      pa_out_ff  <= nxt_pa_out;
      pa_oe_n_ff <= nxt_pa_oe_n;
      pb_out_ff  <= nxt_pb_out;
      pb_oe_n_ff <= nxt_pb_oe_n;
      pb_pu_ff   <= nxt_pb_pu;
      t0ck_ff    <= pa_s2_ff[4];
      ecp_b3_ff  <= nxt_ecp_b3;
      ecp_e7_ff  <= nxt_ecp_e7;
    end
  end

  assign hrdata                  = rdat_ff;
  assign hreadyout               = rdy_ff;
  assign hresp                   = resp_ff;
  assign pa_out                  = pa_out_ff;
  assign pa_oe_n                 = pa_oe_n_ff;
  assign pb_out                  = pb_out_ff;
  assign pb_oe_n                 = pb_oe_n_ff;
  assign pb_pullup_en            = pb_pu_ff;
  assign port_j_pullup_enable    = pj_pu_ff;
  assign port_d_pullup_enable    = pd_pu_ff;
  assign port_e_pullup_enable    = pe_pu_ff;
  assign timer_zero_ext_clock_in = t0ck_ff;
  assign ecp2_on_port_b3         = ecp_b3_ff;
  assign ecp2_on_port_e7         = ecp_e7_ff;
  assign port_b_change_flag      = flag_ff;
  assign port_b_change_wake      = flag_ff;

endmodule

// [bench/gpb_gpio_assertions.sv]
// Checker of bus and pin timing relations for the GPIO block.
`timescale 1ns/100ps
module gpb_gpio_checker (
  // Clock, reset and bus.
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  // Pins and flags.
  input wire logic [5:0]  pa_in,
  input wire logic [7:0]  pb_oe_n,
  input wire logic [7:0]  pb_pullup_en,
  input wire logic        timer_zero_ext_clock_in,
  input wire logic        port_b_change_flag,
  input wire logic        port_b_change_wake
);
  logic       take;
  logic       clr_ff;
  logic [2:0] age_ff;
  assign take = hsel & hready & htrans[1];
  // Counts edges since reset so that startup history is not judged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_ff <= 1'b0;
      age_ff <= 3'h0;
    end else begin
      clr_ff <= take & hwrite & (haddr[7:0] == 8'h1C);
      age_ff <= (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (
    take && hwrite |=> hreadyout) else $error("write stalled");
  a_flag_hold: assert property (
    port_b_change_flag && !clr_ff |=> port_b_change_flag)
    else $error("flag dropped without clear");
  a_timer_sync: assert property (
    age_ff > 3'h3 |-> timer_zero_ext_clock_in == $past(pa_in[4], 3))
    else $error("timer clock input not pin 4");
  a_pullup_reset: assert property (
    age_ff == 3'h0 |-> pb_pullup_en == 8'h00 && pb_oe_n == 8'hFF)
    else $error("pull-ups or direction wrong after reset");
  a_rdata_upper: assert property (
    hreadyout |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_pullup_out: assert property (
    (pb_pullup_en & ~pb_oe_n) == 8'h00) else $error("pull-up on output");
  a_wake_flag: assert property (
    port_b_change_wake == port_b_change_flag) else $error("wake differs");
endmodule
bind gpb_gpio_top gpb_gpio_checker i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .pa_in, .pb_oe_n,
  .pb_pullup_en, .timer_zero_ext_clock_in, .port_b_change_flag,
  .port_b_change_wake);

// [bench/gpb_pin_model.sv]
// Pin level model for the board side of ports A and B.
`timescale 1ns/100ps
module gpb_pin_model (
  // Clock.
  input  wire logic       hclk,
  // Device side.
  input  wire logic [5:0] pa_out,
  input  wire logic [5:0] pa_oe_n,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe_n,
  input  wire logic [7:0] pb_pullup_en,
  // External drivers.
  input  wire logic [5:0] pa_drv,
  input  wire logic [7:0] pb_drv,
  input  wire logic [7:0] pb_drv_en,
  // Resolved levels.
  output logic      [5:0] pa_in,
  output logic      [7:0] pb_in
);
  logic [7:0] last_ff = 8'h00;
  logic [7:0] held;
  // Only driven or pulled levels are remembered; a float keeps the old one.
  assign held = ~pb_oe_n | pb_drv_en | pb_pullup_en;
  always @(posedge hclk) last_ff <= (pb_in & held) | (last_ff & ~held);
  always_comb begin
    pa_in = (pa_out & ~pa_oe_n) | (pa_drv & pa_oe_n);
    // A floating pin shows the inverse of its last level.
    for (int i = 0; i < 8; i++) begin
      if (!pb_oe_n[i]) pb_in[i] = pb_out[i];
      else if (pb_drv_en[i]) pb_in[i] = pb_drv[i];
      else if (pb_pullup_en[i]) pb_in[i] = 1'b1;
      else pb_in[i] = ~last_ff[i];
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking testbench of the GPIO block.
`timescale 1ns/100ps
module testbench;
  import gpb_pkg::*;
  typedef struct packed {logic [7:0] a, w, e, r;} gpb_row_s;
  localparam gpb_row_s ROWS [9] = '{'{8'h04, 8'h3F, 8'h3F, 8'h00},
    '{8'h08, 8'hFF, 8'h3F, 8'h3F}, '{8'h0C, 8'h0B, 8'h0B, 8'h00},
    '{8'h14, 8'hA5, 8'hA5, 8'h00}, '{8'h18, 8'h0F, 8'h0F, 8'hFF},
    '{8'h20, 8'h00, 8'h00, 8'h80}, '{8'h24, 8'h04, 8'h04, 8'h04},
    '{8'h30, 8'hFF, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h3F, 8'h10}};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, mm, j, d, e;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [5:0]  pa_in, pa_out, pa_oe_n, pa_drv;
  logic [7:0]  pb_in, pb_out, pb_oe_n, pb_pu, pb_drv, pb_drv_en;
  logic        flag, b3, e7, tmr, rsp, wake;
  int          bad_count, n_tests, cyc;
  assign hready = hreadyout;
  gpb_gpio_top i_gpb_gpio_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout,
    .hresp(rsp), .memory_to_memory_move(mm), .pa_in, .pa_out, .pa_oe_n,
    .pb_in, .pb_out, .pb_oe_n, .pb_pullup_en(pb_pu),
    .port_j_pullup_enable(j), .port_d_pullup_enable(d),
    .port_e_pullup_enable(e), .ethernet_led_a_out(1'b1),
    .ethernet_led_b_out(1'b1), .pwm_two_output_a(1'b0),
    .timer_zero_ext_clock_in(tmr), .ecp2_on_port_b3(b3),
    .ecp2_on_port_e7(e7), .port_b_change_flag(flag),
    .port_b_change_wake(wake));
  gpb_pin_model i_gpb_pin_model (.hclk, .pa_out, .pa_oe_n, .pb_out,
    .pb_oe_n, .pb_pullup_en(pb_pu), .pa_drv, .pb_drv,
    .pb_drv_en, .pa_in, .pb_in);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] dat);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, dat};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk_flag(input logic exp);
    repeat (3) @(posedge hclk);
    check(flag, exp);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, mm, htrans, haddr, hwdata} = '0;
    pa_drv = 6'h3F;
    pb_drv = 8'h00;
    pb_drv_en = 8'hFF;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    foreach (ROWS[i]) begin
      xfer(1'b0, ROWS[i].a, 8'h00);
      check(q, ROWS[i].r);
    end
    foreach (ROWS[i]) begin
      xfer(1'b1, ROWS[i].a, ROWS[i].w);
      xfer(1'b0, ROWS[i].a, 8'h00);
      check(q, ROWS[i].e);
    end
    check(pb_oe_n, 8'h0F);
    check(pb_out[7:4], 4'hA);
    check(pb_pu, 8'h0F);
    pb_drv <= 8'h03;
    repeat (2) @(posedge hclk);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    check(q, 32'hA3);
    check(rsp, 1'b0);
    xfer(1'b1, OFS_PB_DIR, 8'hFF);
    // Let the released pins pass the synchroniser before the snapshot.
    repeat (4) @(posedge hclk);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    xfer(1'b1, OFS_INT_MAIN, 8'h00);
    chk_flag(1'b0);
    // No pin reads between snapshot and flag wait.
    pb_drv <= 8'h23;
    for (int i = 0; i < 20 && flag !== 1'b1; i++) @(posedge hclk);
    check(flag, 1'b1);
    check(wake, 1'b1);
    xfer(1'b1, OFS_INT_MAIN, 8'h00);
    chk_flag(1'b1);
    mm <= 1'b1;
    xfer(1'b1, OFS_PB_PIN, 8'h00);
    mm <= 1'b0;
    xfer(1'b1, OFS_INT_MAIN, 8'h00);
    chk_flag(1'b1);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    xfer(1'b1, OFS_INT_MAIN, 8'h00);
    chk_flag(1'b0);
    xfer(1'b1, OFS_PB_DIR, 8'h0F);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    xfer(1'b1, OFS_INT_MAIN, 8'h00);
    xfer(1'b1, OFS_PB_LAT, 8'h5A);
    chk_flag(1'b0);
    xfer(1'b1, OFS_PA_DIR, 8'h38);
    xfer(1'b1, OFS_ALT_CFG, 8'h1B);
    chk_flag(1'b0);
    check(pa_out[1:0], 2'b11);
    check(pa_oe_n, 6'h3C);
    check(b3, 1'b1);
    xfer(1'b1, OFS_ALT_CFG, 8'h13);
    xfer(1'b1, OFS_ANA_CFG, 8'h08);
    xfer(1'b0, OFS_PA_PIN, 8'h00);
    check(q, 32'h38);
    check(e7, 1'b1);
    xfer(1'b1, OFS_PA_PIN, 8'h80);
    xfer(1'b1, OFS_PA_LAT, 8'hC0);
    pa_drv <= 6'h2F;
    repeat (6) @(posedge hclk);
    check({j, d, e}, 3'b111);
    check(tmr, 1'b0);
    pb_drv_en <= 8'hF0;
    repeat (2) @(posedge hclk);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    check(q, 32'h5F);
    // Reset again in mid-run; the pull-ups must drop with it.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check(pb_pu, 8'h00);
    check(pb_oe_n, 8'hFF);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, OFS_INT_TWO, 8'h00);
    check(q, 32'h80);
    xfer(1'b0, OFS_PB_PIN, 8'h00);
    check(q, 32'h20);
    conclude();
  end
endmodule
